// File: rtl/gpc_pin_ctrl.sv
// top of one gpio pin: control word, event status and mask, pad steering
// assumes a synchronous register port and pad/rail inputs on clk
//
// Contract
// - select 1: output data from bank register bit; per-pin value writes ignored.
// - select 0: output data from per-pin value; bank bit writes ignored.
// - direction bit sets buffer direction only while gpio function selected.
// - alternate function selected: it controls the pin direction itself.
// - buffer type bit: 1 open drain, 0 push-pull, for every function.
// - edge enabled: 101 rising, 110 falling, 111 either edge.
// - edge disabled: 000 low level, 001 high level; others reserved.
// - edge disabled with code 100: no interrupt events.
// - power code 00 standby rail, 01 main rail; tristate when well off.
// - power code 10: input, output and pulls all off.
// - power code 11: output only, tristated when standby rail off.
// - pull field: none, up, down, or keeper holding last value.
// - only edge detections wake the main clock domain.
// - function field 00 gpio, 01..11 alternate functions 1..3.
// - polarity with alternate function inverts outputs and detection sense.
// - input bit low when output only, high when unpowered or rail down; code forces high for main rail down only, standby rail down passes the pad.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
`include "gpc_map.svh"
module gpc_pin_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // bank output register bit of this pin
  input wire logic bank_wr,
  input wire logic bank_wdata,
  // alternate functions 1..3
  input wire logic [2:0] alt_out,
  input wire logic [2:0] alt_oe,
  // rails
  input wire logic standby_rail,
  input wire logic main_rail_good,
  // pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_ie,
  output logic pull_up_en,
  output logic pull_dn_en,
  output logic keeper_en,
  // events
  output logic pin_event,
  output logic wake_event,
  output logic irq
);
  gpc_cfg_if cfg ();

  logic [1:0] mux, next_mux;
  logic pol, next_pol;
  logic osel, next_osel;
  logic dir, next_dir;
  logic obt, next_obt;
  logic edge_en, next_edge_en;
  logic [2:0] sense, next_sense;
  logic [1:0] pwr, next_pwr;
  logic [1:0] pull, next_pull;
  logic out_data, next_out_data;
  logic [1:0] status, next_status;
  logic [1:0] mask, next_mask;
  logic [31:0] next_rdata;
  logic in_val;
  logic lvl_hit;
  logic edge_hit;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_status;
  logic [1:0] ev;

  assign cfg.mux = mux;
  assign cfg.pol = pol;
  assign cfg.dir = dir;
  assign cfg.obt = obt;
  assign cfg.edge_en = edge_en;
  assign cfg.sense = sense;
  assign cfg.pwr = pwr;
  assign cfg.pull = pull;
  assign cfg.out_data = out_data;

  gpc_pad_mux u_pad (
    .cfg(cfg.sink),
    .alt_out(alt_out),
    .alt_oe(alt_oe),
    .standby_rail(standby_rail),
    .main_rail_good(main_rail_good),
    .pad_in(pad_in),
    .pad_out(pad_out),
    .pad_oe(pad_oe),
    .pad_ie(pad_ie),
    .pull_up_en(pull_up_en),
    .pull_dn_en(pull_dn_en),
    .keeper_en(keeper_en),
    .in_val(in_val)
  );

  gpc_irq_det u_det (
    .clk(clk),
    .rstn(rstn),
    .cfg(cfg.sink),
    .in_val(in_val),
    .lvl_hit(lvl_hit),
    .edge_hit(edge_hit)
  );

  // event outputs
  assign pin_event = lvl_hit | edge_hit;
  assign wake_event = edge_hit;
  assign ev = {wake_event, pin_event};
  assign irq = |(status & mask);

  // address decode
  always_comb begin
    wr_ctrl = 1'b0;
    wr_mask = 1'b0;
    rd_status = 1'b0;
    if (reg_addr == `GPC_ADDR_CTRL) begin
      wr_ctrl = reg_wr;
    end else if (reg_addr == `GPC_ADDR_MASK) begin
      wr_mask = reg_wr;
    end else if (reg_addr == `GPC_ADDR_STATUS) begin
      rd_status = reg_rd;
    end
  end

  // control word next values
  always_comb begin
    next_mux = mux;
    next_pol = pol;
    next_osel = osel;
    next_dir = dir;
    next_obt = obt;
    next_edge_en = edge_en;
    next_sense = sense;
    next_pwr = pwr;
    next_pull = pull;
    next_out_data = out_data;
    next_mask = mask;
    if (wr_ctrl) begin
      next_mux = reg_wdata[`GPC_MUX_HI:`GPC_MUX_LO];
      next_pol = reg_wdata[`GPC_BIT_POL];
      next_osel = reg_wdata[`GPC_BIT_OSEL];
      next_dir = reg_wdata[`GPC_BIT_DIR];
      next_obt = reg_wdata[`GPC_BIT_OBT];
      next_edge_en = reg_wdata[`GPC_BIT_EDGE];
      next_sense = reg_wdata[`GPC_SENSE_HI:`GPC_SENSE_LO];
      next_pwr = reg_wdata[`GPC_PWR_HI:`GPC_PWR_LO];
      next_pull = reg_wdata[`GPC_PULL_HI:`GPC_PULL_LO];
    end
    if (wr_ctrl && !osel) begin
      next_out_data = reg_wdata[`GPC_BIT_ODATA];
    end
    if (bank_wr && osel) begin
      next_out_data = bank_wdata;
    end
    if (wr_mask) begin
      next_mask = reg_wdata[1:0];
    end
  end

  // status: read clears, a new event wins
  always_comb begin
    next_status = status;
    if (rd_status) begin
      next_status = 2'h0;
    end
    next_status = next_status | ev;
  end

  // read data
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == `GPC_ADDR_CTRL) begin
        next_rdata[`GPC_BIT_INPUT] = in_val;
        next_rdata[`GPC_BIT_ODATA] = out_data;
        next_rdata[`GPC_MUX_HI:`GPC_MUX_LO] = mux;
        next_rdata[`GPC_BIT_POL] = pol;
        next_rdata[`GPC_BIT_OSEL] = osel;
        next_rdata[`GPC_BIT_DIR] = dir;
        next_rdata[`GPC_BIT_OBT] = obt;
        next_rdata[`GPC_BIT_EDGE] = edge_en;
        next_rdata[`GPC_SENSE_HI:`GPC_SENSE_LO] = sense;
        next_rdata[`GPC_PWR_HI:`GPC_PWR_LO] = pwr;
        next_rdata[`GPC_PULL_HI:`GPC_PULL_LO] = pull;
      end else if (reg_addr == `GPC_ADDR_STATUS) begin
        next_rdata[1:0] = status;
      end else if (reg_addr == `GPC_ADDR_MASK) begin
        next_rdata[1:0] = mask;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mux <= `GPC_MUX_GPIO;
      pol <= 1'b0;
      osel <= 1'b0;
      dir <= 1'b0;
      obt <= 1'b0;
      edge_en <= 1'b0;
      sense <= `GPC_RST_SENSE;
      pwr <= `GPC_PWR_STBY;
      pull <= `GPC_RST_ZERO2;
      out_data <= 1'b0;
      status <= `GPC_RST_ZERO2;
      mask <= `GPC_RST_ZERO2;
      reg_rdata <= 32'h0000_0000;
    end else begin
      mux <= next_mux;
      pol <= next_pol;
      osel <= next_osel;
      dir <= next_dir;
      obt <= next_obt;
      edge_en <= next_edge_en;
      sense <= next_sense;
      pwr <= next_pwr;
      pull <= next_pull;
      out_data <= next_out_data;
      status <= next_status;
      mask <= next_mask;
      reg_rdata <= next_rdata;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence ctrl_write_odata;
    wr_ctrl && !osel;
  endsequence

  sel_bank_data_a: assert property (
    bank_wr && osel |=> out_data == $past(bank_wdata))
    else $error("bank write not taken while bank source selected");

  sel_pin_data_a: assert property (
    ctrl_write_odata and !(bank_wr && osel) |=> out_data == $past(reg_wdata[`GPC_BIT_ODATA]))
    else $error("per-pin value not taken");

  bank_ignored_a: assert property (
    !osel && bank_wr && !wr_ctrl |=> $stable(out_data))
    else $error("bank write leaked to pin");

  gpio_dir_a: assert property (
    mux == `GPC_MUX_GPIO && !dir |-> !pad_oe)
    else $error("gpio input drives pad");

  alt_dir_a: assert property (
    mux != `GPC_MUX_GPIO && alt_oe[mux - 2'h1] == 1'b0 |-> !pad_oe)
    else $error("alternate disabled yet pad driven");

  open_drain_a: assert property (
    obt && pad_oe |-> pad_out == 1'b0)
    else $error("open drain drove high");

  rise_edge_a: assert property (
    edge_en && sense == `GPC_SENSE_RISE && !(mux != `GPC_MUX_GPIO && pol)
    ##1 $rose(in_val) && $stable(sense) && $stable(edge_en) && $stable(pol) && $stable(mux)
    |-> edge_hit)
    else $error("rising edge missed");

  level_low_a: assert property (
    !edge_en && sense == `GPC_SENSE_LOW && !in_val && mux == `GPC_MUX_GPIO |-> lvl_hit)
    else $error("low level missed");

  no_event_a: assert property (
    gpc_pkg::sense_decode(edge_en, sense) == gpc_pkg::SENSE_NONE |-> !pin_event)
    else $error("event while disabled or reserved");

  well_off_a: assert property (
    (pwr == `GPC_PWR_MAIN && !main_rail_good) || (pwr == `GPC_PWR_STBY && !standby_rail)
    |-> !pad_oe)
    else $error("pad driven with well off");

  unpowered_a: assert property (
    pwr == `GPC_PWR_OFF |-> !pad_oe && !pad_ie && !pull_up_en && !pull_dn_en && !keeper_en)
    else $error("unpowered pad active");

  out_only_a: assert property (
    pwr == `GPC_PWR_OUTONLY |-> !pad_ie && (standby_rail || !pad_oe))
    else $error("output-only pad misbehaves");

  keeper_sel_a: assert property (
    pwr != `GPC_PWR_OFF |-> keeper_en == (pull == `GPC_PULL_KEEP))
    else $error("keeper select wrong");

  wake_edge_a: assert property (
    wake_event |-> edge_en)
    else $error("wake without edge mode");

  polarity_a: assert property (
    mux != `GPC_MUX_GPIO && alt_oe[mux - 2'h1] && !obt && standby_rail
    && pwr == `GPC_PWR_STBY |-> pad_out == (alt_out[mux - 2'h1] ^ pol))
    else $error("alternate polarity wrong");

  input_read_a: assert property (
    reg_rd && reg_addr == `GPC_ADDR_CTRL && pwr == `GPC_PWR_OFF
    |=> reg_rdata[`GPC_BIT_INPUT])
    else $error("unpowered input bit not high");

  status_sticky_a: assert property (
    pin_event |=> (status[`GPC_ST_PIN] && rd_status) or status[`GPC_ST_PIN] [*2])
    else $error("pin status not held");
endmodule

// File: rtl/gpc_map.svh
// register map, field positions and reset values of the pin control block
// assumes a word-aligned byte address on the 8-bit address of the register port
`ifndef GPC_MAP_SVH
`define GPC_MAP_SVH
`define GPC_ADDR_CTRL 8'h00
`define GPC_ADDR_STATUS 8'h04
`define GPC_ADDR_MASK 8'h08
`define GPC_BIT_INPUT 24
`define GPC_BIT_ODATA 16
`define GPC_MUX_HI 13
`define GPC_MUX_LO 12
`define GPC_BIT_POL 11
`define GPC_BIT_OSEL 10
`define GPC_BIT_DIR 9
`define GPC_BIT_OBT 8
`define GPC_BIT_EDGE 7
`define GPC_SENSE_HI 6
`define GPC_SENSE_LO 4
`define GPC_PWR_HI 3
`define GPC_PWR_LO 2
`define GPC_PULL_HI 1
`define GPC_PULL_LO 0
`define GPC_MUX_GPIO 2'h0
`define GPC_PWR_STBY 2'h0
`define GPC_PWR_MAIN 2'h1
`define GPC_PWR_OFF 2'h2
`define GPC_PWR_OUTONLY 2'h3
`define GPC_PULL_UP 2'h1
`define GPC_PULL_DOWN 2'h2
`define GPC_PULL_KEEP 2'h3
`define GPC_SENSE_LOW 3'h0
`define GPC_SENSE_HIGH 3'h1
`define GPC_SENSE_OFF 3'h4
`define GPC_SENSE_RISE 3'h5
`define GPC_SENSE_FALL 3'h6
`define GPC_SENSE_BOTH 3'h7
`define GPC_ST_PIN 0
`define GPC_ST_WAKE 1
`define GPC_RST_SENSE 3'h4
`define GPC_RST_ZERO2 2'h0
`endif

// File: rtl/gpc_pkg.sv
// types and the shared sense decoder of the pin control block
// assumes gpc_map.svh is on the include path
`include "gpc_map.svh"
package gpc_pkg;
  typedef enum logic [2:0] {
    SENSE_NONE, SENSE_LOW, SENSE_HIGH, SENSE_RISE, SENSE_FALL, SENSE_BOTH
  } gpc_sense_t;

  // reserved code combinations give no events
  function automatic gpc_sense_t sense_decode(input logic edge_en, input logic [2:0] code);
    gpc_sense_t m;
    m = SENSE_NONE;
    if (edge_en) begin
      if (code == `GPC_SENSE_RISE) begin
        m = SENSE_RISE;
      end else if (code == `GPC_SENSE_FALL) begin
        m = SENSE_FALL;
      end else if (code == `GPC_SENSE_BOTH) begin
        m = SENSE_BOTH;
      end
    end else if (code == `GPC_SENSE_LOW) begin
      m = SENSE_LOW;
    end else if (code == `GPC_SENSE_HIGH) begin
      m = SENSE_HIGH;
    end
    return m;
  endfunction
endpackage

// File: rtl/gpc_cfg_if.sv
// configuration bundle passed from the register file to pad and detector
// assumes one driver, the register file
`timescale 1ns/1ps
interface gpc_cfg_if;
  logic [1:0] mux;
  logic pol;
  logic dir;
  logic obt;
  logic edge_en;
  logic [2:0] sense;
  logic [1:0] pwr;
  logic [1:0] pull;
  logic out_data;
  modport ctrl (output mux, pol, dir, obt, edge_en, sense, pwr, pull, out_data);
  modport sink (input mux, pol, dir, obt, edge_en, sense, pwr, pull, out_data);
endinterface

// File: rtl/gpc_pad_mux.sv
// pad steering: function mux, buffer type, pad_power_source, pulls, input value
// assumes alternate functions give their own data and enable
`timescale 1ns/1ps
`include "gpc_map.svh"
module gpc_pad_mux (
  // configuration
  gpc_cfg_if.sink cfg,
  // alternate functions 1..3
  input wire logic [2:0] alt_out,
  input wire logic [2:0] alt_oe,
  // rails
  input wire logic standby_rail,
  input wire logic main_rail_good,
  // pad
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pad_ie,
  output logic pull_up_en,
  output logic pull_dn_en,
  output logic keeper_en,
  output logic in_val
);
  logic well_on;
  logic drv_data;
  logic drv_en;
  logic [1:0] idx;

  always_comb begin
    idx = cfg.mux - 2'h1;
    case (cfg.pwr)
      `GPC_PWR_STBY: well_on = standby_rail;
      `GPC_PWR_MAIN: well_on = main_rail_good;
      `GPC_PWR_OUTONLY: well_on = standby_rail;
      default: well_on = 1'b0;
    endcase
    if (cfg.mux == `GPC_MUX_GPIO) begin
      drv_data = cfg.out_data;
      drv_en = cfg.dir;
    end else begin
      drv_data = alt_out[idx] ^ cfg.pol;
      drv_en = alt_oe[idx];
    end
    drv_en = drv_en & well_on;
    if (cfg.obt) begin
      pad_out = 1'b0;
      pad_oe = drv_en & ~drv_data;
    end else begin
      pad_out = drv_data;
      pad_oe = drv_en;
    end
    pad_ie = well_on && (cfg.pwr != `GPC_PWR_OUTONLY);
    pull_up_en = (cfg.pwr != `GPC_PWR_OFF) && (cfg.pull == `GPC_PULL_UP);
    pull_dn_en = (cfg.pwr != `GPC_PWR_OFF) && (cfg.pull == `GPC_PULL_DOWN);
    keeper_en = (cfg.pwr != `GPC_PWR_OFF) && (cfg.pull == `GPC_PULL_KEEP);
    if (cfg.pwr == `GPC_PWR_OUTONLY) begin
      in_val = 1'b0;
    end else if (cfg.pwr == `GPC_PWR_OFF) begin
      in_val = 1'b1;
    end else if (cfg.pwr == `GPC_PWR_MAIN && !main_rail_good) begin
      in_val = 1'b1;
    end else begin
      in_val = pad_in;
    end
  end
endmodule

// File: rtl/gpc_irq_det.sv
// level and edge detection on the pin input value
// assumes in_val already synchronous to clk
`timescale 1ns/1ps
`include "gpc_map.svh"
module gpc_irq_det (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // configuration and input
  gpc_cfg_if.sink cfg,
  input wire logic in_val,
  // detections
  output logic lvl_hit,
  output logic edge_hit
);
  logic prev;
  logic primed;
  logic next_prev;
  logic next_primed;
  logic inv;
  logic cur_s;
  logic prev_s;
  gpc_pkg::gpc_sense_t mode;

  always_comb begin
    next_prev = in_val;
    next_primed = 1'b1;
    inv = (cfg.mux != `GPC_MUX_GPIO) && cfg.pol;
    cur_s = in_val ^ inv;
    prev_s = prev ^ inv;
    mode = gpc_pkg::sense_decode(cfg.edge_en, cfg.sense);
    lvl_hit = 1'b0;
    edge_hit = 1'b0;
    case (mode)
      gpc_pkg::SENSE_LOW: lvl_hit = ~cur_s;
      gpc_pkg::SENSE_HIGH: lvl_hit = cur_s;
      gpc_pkg::SENSE_RISE: edge_hit = primed & cur_s & ~prev_s;
      gpc_pkg::SENSE_FALL: edge_hit = primed & ~cur_s & prev_s;
      gpc_pkg::SENSE_BOTH: edge_hit = primed & (cur_s ^ prev_s);
      default: edge_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev <= 1'b0;
      primed <= 1'b0;
    end else begin
      prev <= next_prev;
      primed <= next_primed;
    end
  end
endmodule

// File: tb/gpc_pad_model.sv
// board side of one gpio pad: device drive, external driver, pulls, keeper
// assumes pad_in is taken to the device on clk, like a synchronised pad
`timescale 1ns/1ps
module gpc_pad_model (
  // clock
  input wire logic clk,
  // device side
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic pull_up_en,
  input wire logic pull_dn_en,
  input wire logic keeper_en,
  // external driver
  input wire logic ext_en,
  input wire logic ext_val,
  output logic pad_in
);
  logic last = 1'b0;
  logic lvl;
  always_comb begin
    if (pad_oe) begin
      lvl = pad_out;
    end else if (ext_en) begin
      lvl = ext_val;
    end else if (pull_up_en) begin
      lvl = 1'b1;
    end else if (pull_dn_en) begin
      lvl = 1'b0;
    end else if (keeper_en) begin
      lvl = last;
    end else begin
      // floating wire wanders
      lvl = ~last;
    end
  end
  always @(posedge clk) begin
    last <= lvl;
    pad_in <= lvl;
  end
endmodule

// File: tb/test_gpio_pin_control.sv
// self-checking bench of one gpio pin control block
// assumes the design files and gpc_map.svh are compiled first
`timescale 1ns/1ps
module test_gpio_pin_control;
  logic clk, rstn, reg_wr, reg_rd, bank_wr, bank_wdata;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [2:0] alt_out, alt_oe;
  logic standby_rail, main_rail_good, pad_in, pad_out, pad_oe, pad_ie;
  logic pull_up_en, pull_dn_en, keeper_en, pin_event, wake_event, irq;
  logic ext_en, ext_val;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  logic [15:0] cfg [12] = '{16'h0000, 16'h0010, 16'h0040, 16'h0020, 16'h0030,
    16'h0050, 16'h0060, 16'h0070, 16'h00d0, 16'h00e0, 16'h00f0, 16'h18d0};
  logic [7:0] ev [12] = '{8'h45, 8'h54, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'hc0, 8'h0c, 8'hcc, 8'h0c};

  gpc_pin_ctrl DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bank_wr(bank_wr),
    .bank_wdata(bank_wdata), .alt_out(alt_out), .alt_oe(alt_oe),
    .standby_rail(standby_rail), .main_rail_good(main_rail_good), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_ie(pad_ie), .pull_up_en(pull_up_en),
    .pull_dn_en(pull_dn_en), .keeper_en(keeper_en), .pin_event(pin_event),
    .wake_event(wake_event), .irq(irq));
  gpc_pad_model pad (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .keeper_en(keeper_en),
    .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      $display("ERROR %0t: run timed out", $time);
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic pause(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    rd(a, v);
    chk(v, exp);
  endtask

  task automatic bank(input logic v);
    @(posedge clk);
    bank_wr <= 1'b1;
    bank_wdata <= v;
    @(posedge clk);
    bank_wr <= 1'b0;
    #1;
  endtask

  initial begin
    rstn = 1'b0;
    {reg_wr, reg_rd, bank_wr, bank_wdata, ext_val} = '0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    alt_out = 3'h0;
    alt_oe = 3'h0;
    standby_rail = 1'b1;
    main_rail_good = 1'b1;
    ext_en = 1'b1;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rdc(8'h00, 32'h0000_0040);
    rdc(8'h04, 32'h0);
    rdc(8'h08, 32'h0);
    rdc(8'h0c, 32'h0);
    wr(8'h04, 32'hffff_ffff);
    rdc(8'h04, 32'h0);
    chk(irq, 1'b0);
    ext_en <= 1'b0;
    wr(8'h00, 32'h0001_0200);
    chk(pad_oe, 1'b1);
    bank(1'b0);
    chk(pad_out, 1'b1);
    wr(8'h00, 32'h0001_0600);
    bank(1'b0);
    chk(pad_out, 1'b0);
    wr(8'h00, 32'h0001_0600);
    chk(pad_out, 1'b0);
    pause(2);
    rdc(8'h00, 32'h0000_0600);
    bank(1'b1);
    pause(2);
    rdc(8'h00, 32'h0101_0600);
    wr(8'h00, 32'h0000_0700);
    chk({pad_oe, pad_out}, 2'b00);
    bank(1'b0);
    chk({pad_oe, pad_out}, 2'b10);
    wr(8'h00, 32'h0000_0400);
    chk(pad_oe, 1'b0);
    for (int m = 1; m < 4; m++) begin
      for (int p = 0; p < 2; p++) begin
        alt_oe <= 3'h1 << (m - 1);
        alt_out <= 3'h1 << (m - 1);
        wr(8'h00, (32'(m) << 12) | (32'(p) << 11));
        chk({pad_oe, pad_out}, {1'b1, 1'(1 - p)});
      end
    end
    alt_oe <= 3'h0;
    wr(8'h00, 32'h0001_0201);
    pause(2);
    chk({pad_ie, pad_oe, pull_up_en}, 3'b111);
    rdc(8'h00, 32'h0101_0201);
    main_rail_good <= 1'b0;
    wr(8'h00, 32'h0001_0205);
    chk({pad_oe, pull_up_en}, 2'b01);
    rdc(8'h00, 32'h0101_0205);
    main_rail_good <= 1'b1;
    wr(8'h00, 32'h0001_0209);
    chk({pad_ie, pad_oe, pull_up_en}, 3'b000);
    rdc(8'h00, 32'h0101_0209);
    wr(8'h00, 32'h0000_030d);
    chk({pad_ie, pad_oe}, 2'b01);
    rdc(8'h00, 32'h0000_030d);
    standby_rail <= 1'b0;
    pause(1);
    chk(pad_oe, 1'b0);
    standby_rail <= 1'b1;
    for (int q = 0; q < 4; q++) begin
      wr(8'h00, 32'(q));
      chk({pull_up_en, pull_dn_en, keeper_en}, {q == 1, q == 2, q == 3});
    end
    ext_en <= 1'b1;
    ext_val <= 1'b0;
    wr(8'h08, 32'h3);
    for (int i = 0; i < 12; i++) begin
      wr(8'h00, 32'(cfg[i]));
      pause(3);
      rd(8'h04, d);
      ext_val <= 1'b1;
      pause(5);
      chk(irq, |ev[i][7:6]);
      rdc(8'h04, 32'(ev[i][7:6]));
      rdc(8'h04, 32'(ev[i][5:4]));
      ext_val <= 1'b0;
      pause(5);
      rdc(8'h04, 32'(ev[i][3:2]));
      rdc(8'h04, 32'(ev[i][1:0]));
    end
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h0000_00d0);
    ext_val <= 1'b1;
    pause(1);
    chk({pin_event, wake_event}, 2'b11);
    pause(1);
    chk({pin_event, wake_event}, 2'b00);
    pause(3);
    chk(irq, 1'b0);
    wr(8'h08, 32'h2);
    pause(2);
    chk(irq, 1'b1);
    rdc(8'h04, 32'h3);
    pause(2);
    chk(irq, 1'b0);
    wrap_up();
  end
endmodule
